// ==== design/seipc_defs.svh ====
`ifndef SEIPC_DEFS_SVH
`define SEIPC_DEFS_SVH

// Target port addressing and bit positions within a byte slot.
`define SEIPC_TARGET_ADDR    7'h48
`define SEIPC_BIT_LAST_DATA  4'h7
`define SEIPC_BIT_ACK        4'h8
`define SEIPC_BIT_PRE        4'hf

// Protocol auto-detection and session-end codes.
`define SEIPC_PROTO_A_NAD    8'h5a
`define SEIPC_EOS_PCB_A      8'hc5
`define SEIPC_EOS_PCB_B      8'hcf

// Bus rate limits in kHz and the system clock in MHz.
`define SEIPC_HS_SCL_MAX_KHZ  3400
`define SEIPC_FS_SCL_MAX_KHZ  1000
`define SEIPC_CTL_SCL_MAX_KHZ 400
`define SEIPC_CLK_MHZ         250

// Half period of the controller clock in system cycles, rounded up.
`define SEIPC_CTL_HALF_CYC ((`SEIPC_CLK_MHZ * 1000 + 2 * `SEIPC_CTL_SCL_MAX_KHZ - 1) / (2 * `SEIPC_CTL_SCL_MAX_KHZ))

// Boot strap settle time and synchroniser reset levels {scl, sda, ena, card_rst_n, wake}.
`define SEIPC_BOOT_CYC       3'h4
`define SEIPC_SYNC_RST       5'h1e

`endif

// ==== design/seipc_pkg.sv ====
package seipc_pkg;

   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_WRITE, ST_READ, ST_SKIP} seipc_bus_type;

   typedef enum logic [1:0] {PW_BOOT, PW_RUN, PW_PD, PW_DPD} seipc_pwr_type;

endpackage : seipc_pkg

// ==== design/seipc_link_if.sv ====
`timescale 1ns/100ps
`default_nettype none

interface seipc_link_if;
   logic [7:0] byte_val;
   logic       byte_tgl;
   logic       clr_n;

   modport link (output byte_val, output byte_tgl, input clr_n);
   modport core (input byte_val, input byte_tgl, output clr_n);
endinterface : seipc_link_if

`default_nettype wire

// ==== design/seipc_link_rx.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "seipc_defs.svh"

module seipc_link_rx (
   // Link clock and data
   input  wire logic  scl,
   input  wire logic  sda,
   // Reset
   input  wire logic  rst_n,
   // Byte carrier
   seipc_link_if.link lk
);

   logic [3:0] cnt_q,  cnt_d;
   logic [6:0] sh_q,   sh_d;
   logic [7:0] byte_q, byte_d;
   logic       tgl_q,  tgl_d;

   // Bits are taken on the rising edge of the bus clock; the ninth slot is the acknowledge.
   always_comb begin
      cnt_d  = cnt_q + 4'h1;
      sh_d   = {sh_q[5:0], sda};
      byte_d = byte_q;
      tgl_d  = tgl_q;
      if (cnt_q == `SEIPC_BIT_LAST_DATA) begin
         byte_d = {sh_q, sda};
         tgl_d  = ~tgl_q;
      end
      if (cnt_q == `SEIPC_BIT_ACK) begin
         cnt_d = 4'h0;
         sh_d  = sh_q;
      end
   end

   // The core clears the bit position at every start so framing never drifts.
   always_ff @(posedge scl or negedge lk.clr_n) begin
      if (!lk.clr_n) begin
         cnt_q <= 4'h0;
         sh_q  <= 7'h00;
      end else begin
         cnt_q <= cnt_d;
         sh_q  <= sh_d;
      end
   end

   // The toggle survives frame clears, so the core never sees a false byte event.
   always_ff @(posedge scl or negedge rst_n) begin
      if (!rst_n) begin
         byte_q <= 8'h00;
         tgl_q  <= 1'b0;
      end else begin
         byte_q <= byte_d;
         tgl_q  <= tgl_d;
      end
   end

   assign lk.byte_val = byte_q;
   assign lk.byte_tgl = tgl_q;

endmodule : seipc_link_rx

`default_nettype wire

// ==== design/seipc_top.sv ====
// Notes on behaviour
// - After defaults the target port answers at seven-bit address 0x48.
// - The target port carries block-protocol frames both ways between host and device.
// - With stretching on the target port runs up to 3.4 MHz high-speed clock.
// - With stretching off the host keeps the bus clock at or below 1.0 MHz.
// - Clock stretching is off after reset; SCL is never held low until configured.
// - The first received frame selects one of two protocol variants automatically.
// - The secondary controller clock never runs faster than 400 kHz.
// - The secondary controller runs only while the target port is the active interface.
// - Manual and automatic Power-down entry are disabled until reconfigured.
// - When enabled, Power-down follows the end-of-session or release request.
// - In Power-down clocks stop and execution halts; state is kept.
// - Every output holds its level throughout Power-down.
// - A falling edge on the data line wakes the device from Power-down.
// - With card interface enabled, card reset also ends Power-down; the device reboots.
// - Card reset acts only when the card interface is enabled.
// - Enable pin low enters Deep Power-down and removes internal and regulated power.
// - Enable pin high again leaves Deep Power-down.
// - Deep Power-down clears configuration and status but keeps rx_data and the stored address and transmit bytes; the device reboots.
// - Commands are taken only on the interface selected at boot.
`timescale 1ns/100ps
`default_nettype none
`include "seipc_defs.svh"

module seipc_top (
   // System
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Target bus pins; scl_i also clocks the receive shifter
   input  wire logic       scl_i,
   output var  logic       scl_o,
   output var  logic       scl_oe,
   input  wire logic       sda_i,
   output var  logic       sda_o,
   output var  logic       sda_oe,
   // Secondary controller clock
   input  wire logic       ctl_req,
   output var  logic       ctl_scl_o,
   output var  logic       ctl_scl_oe,
   output var  logic       ctl_active,
   // Power and card reset pins
   input  wire logic       deep_sleep_enable_pin,
   input  wire logic       card_rst_n,
   input  wire logic       card_if_en,
   // Configuration
   input  wire logic       cfg_wr,
   input  wire logic       cfg_stretch_en,
   input  wire logic       cfg_pd_manual_en,
   input  wire logic       cfg_pd_auto_en,
   input  wire logic       pd_req,
   // Received and transmitted bytes
   output var  logic [7:0] rx_data,
   output var  logic       rx_valid,
   input  wire logic       rx_ready,
   output var  logic       rx_overrun,
   input  wire logic [7:0] tx_data,
   output var  logic       tx_take,
   // Status
   output var  logic       if_i2c,
   output var  logic       proto_known,
   output var  logic       proto_b,
   output var  logic       high_speed_bus_mode,
   output var  logic       pd_active,
   output var  logic       clk_run,
   output var  logic       cpu_halt,
   output var  logic       vout_en
);

   seipc_link_if lk_if ();

   seipc_link_rx u_rx (
      .scl   (scl_i),
      .sda   (sda_i),
      .rst_n (rst_n),
      .lk    (lk_if.link)
   );

   // Asynchronous wake: armed while powered down, set by any falling data edge.
   logic wake_q;
   always_ff @(negedge sda_i or negedge pd_active) begin
      if (!pd_active) begin
         wake_q <= 1'b0;
      end else begin
         wake_q <= 1'b1;
      end
   end

   // Pin synchronisers; a change counts once stages two and three agree.
   logic [4:0] s1_q, s2_q, s3_q, f_q, f_d;
   logic [2:0] tgl_q, tgl_d;
   always_comb begin
      f_d = f_q;
      for (int i = 0; i < 5; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            f_d[i] = s3_q[i];
         end
      end
      tgl_d = {tgl_q[1:0], lk_if.byte_tgl};
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q  <= `SEIPC_SYNC_RST;
         s2_q  <= `SEIPC_SYNC_RST;
         s3_q  <= `SEIPC_SYNC_RST;
         f_q   <= `SEIPC_SYNC_RST;
         tgl_q <= 3'h0;
      end else begin
         s1_q  <= {scl_i, sda_i, deep_sleep_enable_pin, card_rst_n, wake_q};
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         f_q   <= f_d;
         tgl_q <= tgl_d;
      end
   end

   logic scl_f, sda_f, ena_f, crst_f, wake_f;
   assign scl_f  = f_q[4];
   assign sda_f  = f_q[3];
   assign ena_f  = f_q[2];
   assign crst_f = f_q[1];
   assign wake_f = f_q[0];

   seipc_pkg::seipc_bus_type st_q, st_d;
   seipc_pkg::seipc_pwr_type pwr_q, pwr_d;
   logic [3:0] bit_q, bit_d;
   logic [7:0] addr_q, addr_d, txb_q, txb_d, rxd_d;
   logic [1:0] prv_q, prv_d, bidx_q, bidx_d;
   logic [2:0] boot_q, boot_d;
   logic       clr_n_q, clr_n_d, sda_oe_d, scl_oe_d, rxv_d, ovr_d, take_d, pk_d, pb_d;
   logic       eos_q, eos_d, mnack_q, mnack_d, str_q, str_d, pdm_q, pdm_d, pda_q, pda_d;
   logic       i2c_d, pd_d, run_d, halt_d, vout_d;
   logic       scl_rise, scl_fall, start_c, stop_c, byte_ev, soft_rst, pd_exit, run_c, addr_hit;

   function automatic logic eos_code(input logic variant_b, input logic [7:0] pcb);
      eos_code = variant_b ? (pcb == `SEIPC_EOS_PCB_B) : (pcb == `SEIPC_EOS_PCB_A);
   endfunction : eos_code

   assign lk_if.clr_n = clr_n_q;

   always_comb begin
      scl_rise = scl_f & ~prv_q[1];
      scl_fall = ~scl_f & prv_q[1];
      start_c  = scl_f & prv_q[1] & prv_q[0] & ~sda_f;
      stop_c   = scl_f & prv_q[1] & ~prv_q[0] & sda_f;
      byte_ev  = tgl_q[2] ^ tgl_q[1];
      soft_rst = ~ena_f | (card_if_en & ~crst_f);
      pd_exit  = (pwr_q == seipc_pkg::PW_PD) & (wake_f | start_c);
      run_c    = if_i2c & ((pwr_q == seipc_pkg::PW_RUN) | pd_exit);
      addr_hit = (addr_q[7:1] == `SEIPC_TARGET_ADDR);
      prv_d  = {scl_f, sda_f};
      st_d   = st_q;   pwr_d  = pwr_q;   bit_d  = bit_q;   addr_d = addr_q;
      txb_d  = txb_q;  bidx_d = bidx_q;  boot_d = boot_q;  clr_n_d = clr_n_q;
      sda_oe_d = sda_oe; scl_oe_d = scl_oe; rxd_d = rx_data; rxv_d = rx_valid;
      ovr_d  = rx_overrun; take_d = 1'b0; pk_d = proto_known; pb_d = proto_b;
      eos_d  = eos_q;  mnack_d = mnack_q; str_d = str_q;  pdm_d = pdm_q;   pda_d = pda_q;
      i2c_d  = if_i2c; pd_d = pd_active; run_d = clk_run; halt_d = cpu_halt; vout_d = vout_en;
      if (soft_rst) begin
         // Configuration, protocol choice and bus state restart; rx_data and the stored address and transmit bytes survive.
         st_d = seipc_pkg::ST_IDLE; bit_d = `SEIPC_BIT_PRE; clr_n_d = 1'b0;
         sda_oe_d = 1'b0; scl_oe_d = 1'b0; rxv_d = 1'b0; ovr_d = 1'b0; pk_d = 1'b0; pb_d = 1'b0;
         eos_d = 1'b0; str_d = 1'b0; pdm_d = 1'b0; pda_d = 1'b0; i2c_d = 1'b0; boot_d = 3'h0;
         pd_d = 1'b0; halt_d = 1'b1; run_d = ena_f; vout_d = ena_f;
         pwr_d = ena_f ? seipc_pkg::PW_BOOT : seipc_pkg::PW_DPD;
      end else begin
         case (pwr_q)
            seipc_pkg::PW_DPD: begin
               pwr_d = seipc_pkg::PW_BOOT;
               vout_d = 1'b1;
               run_d = 1'b1;
            end
            seipc_pkg::PW_BOOT: begin
               boot_d = boot_q + 3'h1;
               if (boot_q == `SEIPC_BOOT_CYC) begin
                  i2c_d = scl_f & sda_f;
                  pwr_d = seipc_pkg::PW_RUN;
                  halt_d = 1'b0;
               end
            end
            seipc_pkg::PW_PD: begin
               if (pd_exit) begin
                  pwr_d = seipc_pkg::PW_RUN;
                  pd_d = 1'b0; run_d = 1'b1; halt_d = 1'b0;
               end
            end
            seipc_pkg::PW_RUN: begin
               if (cfg_wr) begin
                  str_d = cfg_stretch_en;
                  pdm_d = cfg_pd_manual_en;
                  pda_d = cfg_pd_auto_en;
               end
               if (pd_req && pdm_q && st_q == seipc_pkg::ST_IDLE) begin
                  pwr_d = seipc_pkg::PW_PD;
                  pd_d = 1'b1; run_d = 1'b0; halt_d = 1'b1;
               end
            end
            default: pwr_d = seipc_pkg::PW_BOOT;
         endcase
         // Bus logic is frozen in Power-down, so every output keeps its level.
         if (run_c) begin
            if (rx_valid && rx_ready) begin
               rxv_d = 1'b0;
            end
            if (stop_c) begin
               if (st_q == seipc_pkg::ST_WRITE && eos_q && pda_q) begin
                  pwr_d = seipc_pkg::PW_PD;
                  pd_d = 1'b1; run_d = 1'b0; halt_d = 1'b1;
               end
               st_d = seipc_pkg::ST_IDLE; clr_n_d = 1'b0; sda_oe_d = 1'b0; scl_oe_d = 1'b0;
            end else if (start_c) begin
               st_d = seipc_pkg::ST_ADDR; bit_d = `SEIPC_BIT_PRE; clr_n_d = 1'b0;
               sda_oe_d = 1'b0; bidx_d = 2'h0; eos_d = 1'b0;
            end else begin
               if (st_q != seipc_pkg::ST_IDLE && !clr_n_q && !scl_f) begin
                  clr_n_d = 1'b1;
               end
               if (byte_ev && st_q == seipc_pkg::ST_ADDR) begin
                  addr_d = lk_if.byte_val;
               end
               if (byte_ev && st_q == seipc_pkg::ST_WRITE) begin
                  ovr_d = rx_overrun | rxv_d;
                  rxd_d = lk_if.byte_val;
                  rxv_d = 1'b1;
                  if (bidx_q == 2'h0 && !proto_known) begin
                     pk_d = 1'b1;
                     pb_d = (lk_if.byte_val != `SEIPC_PROTO_A_NAD);
                  end
                  if (bidx_q == 2'h1 && eos_code(proto_b, lk_if.byte_val)) begin
                     eos_d = 1'b1;
                  end
                  if (bidx_q != 2'h3) begin
                     bidx_d = bidx_q + 2'h1;
                  end
               end
               if (scl_rise && bit_q == `SEIPC_BIT_ACK && st_q == seipc_pkg::ST_READ) begin
                  mnack_d = sda_f;
               end
               if (scl_oe && !rx_valid) begin
                  scl_oe_d = 1'b0;
               end
               if (scl_fall && st_q != seipc_pkg::ST_IDLE && st_q != seipc_pkg::ST_SKIP) begin
                  if (bit_q == `SEIPC_BIT_LAST_DATA) begin
                     bit_d = `SEIPC_BIT_ACK;
                     sda_oe_d = (st_q == seipc_pkg::ST_WRITE) | ((st_q == seipc_pkg::ST_ADDR) & addr_hit);
                  end else if (bit_q == `SEIPC_BIT_ACK) begin
                     bit_d = 4'h0;
                     sda_oe_d = 1'b0;
                     if (st_q == seipc_pkg::ST_ADDR && !addr_hit) begin
                        st_d = seipc_pkg::ST_SKIP;
                     end else if (st_q == seipc_pkg::ST_READ && mnack_q) begin
                        st_d = seipc_pkg::ST_SKIP;
                     end else if (st_q == seipc_pkg::ST_WRITE || !addr_q[0] && st_q == seipc_pkg::ST_ADDR) begin
                        st_d = seipc_pkg::ST_WRITE;
                        scl_oe_d = str_q & rx_valid;
                     end else begin
                        st_d = seipc_pkg::ST_READ;
                        txb_d = tx_data;
                        take_d = 1'b1;
                        sda_oe_d = ~tx_data[7];
                     end
                  end else begin
                     bit_d = bit_q + 4'h1;
                     if (st_q == seipc_pkg::ST_READ) begin
                        sda_oe_d = ~txb_q[3'h6 - bit_q[2:0]];
                     end
                  end
               end
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= seipc_pkg::ST_IDLE;   pwr_q <= seipc_pkg::PW_BOOT; bit_q <= `SEIPC_BIT_PRE;
         addr_q <= 8'h00; txb_q <= 8'h00; prv_q <= 2'h3; bidx_q <= 2'h0; boot_q <= 3'h0;
         clr_n_q <= 1'b0; eos_q <= 1'b0; mnack_q <= 1'b0;
         str_q <= 1'b0;   pdm_q <= 1'b0; pda_q <= 1'b0;
         scl_o <= 1'b0; sda_o <= 1'b0; scl_oe <= 1'b0; sda_oe <= 1'b0;
         rx_data <= 8'h00; rx_valid <= 1'b0; rx_overrun <= 1'b0; tx_take <= 1'b0;
         if_i2c <= 1'b0; proto_known <= 1'b0; proto_b <= 1'b0; high_speed_bus_mode <= 1'b0;
         pd_active <= 1'b0; clk_run <= 1'b1; cpu_halt <= 1'b1; vout_en <= 1'b1;
      end else begin
         st_q <= st_d;     pwr_q <= pwr_d;     bit_q <= bit_d;
         addr_q <= addr_d; txb_q <= txb_d;     prv_q <= prv_d;   bidx_q <= bidx_d; boot_q <= boot_d;
         clr_n_q <= clr_n_d; eos_q <= eos_d;   mnack_q <= mnack_d;
         str_q <= str_d;   pdm_q <= pdm_d;     pda_q <= pda_d;
         scl_o <= 1'b0;    sda_o <= 1'b0;      scl_oe <= scl_oe_d; sda_oe <= sda_oe_d;
         rx_data <= rxd_d; rx_valid <= rxv_d;  rx_overrun <= ovr_d; tx_take <= take_d;
         if_i2c <= i2c_d;  proto_known <= pk_d; proto_b <= pb_d;
         high_speed_bus_mode <= str_d;
         pd_active <= pd_d; clk_run <= run_d;  cpu_halt <= halt_d; vout_en <= vout_d;
      end
   end

   // Secondary controller clock, divided down from the system clock.
   logic [8:0] ctl_cnt_q, ctl_cnt_d;
   logic       ctl_oe_d, ctl_act_d, ctl_run_c;
   always_comb begin
      ctl_run_c = ctl_req & if_i2c & (pwr_q == seipc_pkg::PW_RUN) & ~soft_rst;
      ctl_cnt_d = ctl_cnt_q;
      ctl_oe_d  = ctl_scl_oe;
      ctl_act_d = ctl_active;
      if (pwr_q != seipc_pkg::PW_PD || soft_rst) begin
         ctl_act_d = ctl_run_c;
         if (!ctl_run_c) begin
            ctl_cnt_d = 9'h000;
            ctl_oe_d  = 1'b0;
         end else if (ctl_cnt_q == 9'(`SEIPC_CTL_HALF_CYC - 1)) begin
            ctl_cnt_d = 9'h000;
            ctl_oe_d  = ~ctl_scl_oe;
         end else begin
            ctl_cnt_d = ctl_cnt_q + 9'h001;
         end
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl_cnt_q  <= 9'h000;
         ctl_scl_oe <= 1'b0;
         ctl_active <= 1'b0;
         ctl_scl_o  <= 1'b0;
      end else begin
         ctl_cnt_q  <= ctl_cnt_d;
         ctl_scl_oe <= ctl_oe_d;
         ctl_active <= ctl_act_d;
         ctl_scl_o  <= 1'b0;
      end
   end

endmodule : seipc_top

`default_nettype wire

// ==== tb/seipc_top_sva.sv ====
`timescale 1ns/100ps
`default_nettype none

module seipc_top_sva (
   // System
   input wire logic clk,
   input wire logic rst_n,
   // Pins
   input wire logic sda_i,
   input wire logic scl_oe,
   input wire logic sda_oe,
   input wire logic ctl_scl_oe,
   input wire logic ctl_active,
   input wire logic deep_sleep_enable_pin,
   input wire logic card_rst_n,
   input wire logic card_if_en,
   // Status
   input wire logic if_i2c,
   input wire logic high_speed_bus_mode,
   input wire logic pd_active,
   input wire logic clk_run,
   input wire logic cpu_halt,
   input wire logic vout_en
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Cycles since the controller clock last changed, armed once a change is seen while active.
   logic [9:0] gap_q, gap_d;
   logic       seen_q, seen_d, prev_q;
   always_comb begin
      gap_d  = (ctl_scl_oe != prev_q) ? 10'h000 : ((gap_q == 10'h3ff) ? gap_q : gap_q + 10'h001);
      seen_d = ctl_active & ((ctl_scl_oe != prev_q) | seen_q);
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gap_q  <= 10'h000;
         seen_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         gap_q  <= gap_d;
         seen_q <= seen_d;
         prev_q <= ctl_scl_oe;
      end
   end

   chk_ctl_needs_tgt: assert property (ctl_active |-> if_i2c)
      else $error("controller clock runs without target port");
   chk_ctl_rate_max: assert property (ctl_active && seen_q && (ctl_scl_oe != prev_q) |-> gap_q >= 10'h138)
      else $error("controller clock too fast");
   chk_pd_clk_stop: assert property (pd_active |-> !clk_run && cpu_halt)
      else $error("clocks run in power-down");
   chk_pd_out_hold: assert property (pd_active && $past(pd_active) |-> $stable({scl_oe, sda_oe, ctl_scl_oe, vout_en}))
      else $error("output moved in power-down");
   chk_stretch_off: assert property (!high_speed_bus_mode |-> !scl_oe)
      else $error("clock held low with stretching off");
   chk_dpd_entry: assert property ($fell(deep_sleep_enable_pin) |-> ##[1:8] !vout_en && !clk_run)
      else $error("deep power-down not entered");
   chk_dpd_exit: assert property ($rose(deep_sleep_enable_pin) |-> ##[1:12] vout_en)
      else $error("deep power-down not left");
   chk_dpd_clean: assert property (!vout_en |-> !pd_active && !high_speed_bus_mode && !ctl_active)
      else $error("state kept in deep power-down");
   chk_card_ignored: assert property (!card_if_en && !card_rst_n && if_i2c && deep_sleep_enable_pin
      && $past(deep_sleep_enable_pin, 5) |=> if_i2c)
      else $error("card reset acted while disabled");
   chk_sda_wake: assert property (pd_active && $fell(sda_i) |-> ##[1:8] !pd_active)
      else $error("no wake on data fall");
endmodule : seipc_top_sva

bind seipc_top seipc_top_sva u_seipc_top_sva (.*);

`default_nettype wire

// ==== tb/seipc_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module seipc_host_model (
   // Open-drain drives, high = released
   output var logic scl_h,
   output var logic sda_h,
   // Wired bus levels
   input wire logic scl_ln,
   input wire logic sda_ln
);
   logic lck;
   initial begin
      scl_h = 1'b1;
      sda_h = 1'b1;
      lck   = 1'b0;
      #1.3;
      forever #3 lck = ~lck;
   end

   // Half period of 84 ticks keeps the bus clock just under 1 MHz.
   task automatic tk(input int n);
      repeat (n) @(posedge lck);
   endtask : tk

   task automatic start;
      tk(84);
      sda_h <= 1'b0;
      tk(84);
      scl_h <= 1'b0;
   endtask : start

   task automatic stop;
      tk(10);
      sda_h <= 1'b0;
      tk(74);
      scl_h <= 1'b1;
      tk(84);
      sda_h <= 1'b1;
      tk(84);
   endtask : stop

   // A stretched clock is waited out before the high phase is timed.
   task automatic bit_io(input logic b, output logic s);
      tk(10);
      sda_h <= b;
      tk(74);
      scl_h <= 1'b1;
      for (int n = 0; n < 4000 && !scl_ln; n++) @(posedge lck);
      if (!scl_ln) seipc_top_tb.bad_count++;
      tk(84);
      s = sda_ln;
      scl_h <= 1'b0;
   endtask : bit_io

   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(b[i], s);
      bit_io(1'b1, s);
      ack = !s;
   endtask : wbyte

   task automatic rbyte(input logic nack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, s);
         b[i] = s;
      end
      bit_io(nack, s);
   endtask : rbyte
endmodule : seipc_host_model

`default_nettype wire

// ==== tb/seipc_top_tb.sv ====
`timescale 1ns/100ps
`default_nettype none

`define seipc_chk(got, exp) begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end

module seipc_top_tb;
   logic       clk, rst_n, scl_h, sda_h, ack, rx_ready, ctl_req;
   logic       deep_sleep_enable_pin, card_rst_n, card_if_en, cfg_wr, cfg_stretch_en;
   logic       cfg_pd_manual_en, cfg_pd_auto_en, pd_req;
   logic [7:0] tx_data, rx_data, rx_last, rd;
   logic       scl_o, scl_oe, sda_o, sda_oe, ctl_scl_o, ctl_scl_oe, ctl_active, rx_valid, rx_overrun;
   logic       tx_take, if_i2c, proto_known, proto_b, high_speed_bus_mode, pd_active, clk_run;
   logic       cpu_halt, vout_en;
   wire logic  scl_i, sda_i;
   int         bad_count, comparisons, cyc_n, take_n;

   assign scl_i = scl_h & ~scl_oe;
   assign sda_i = sda_h & ~sda_oe;

   seipc_top u_seipc_top (.*);
   seipc_host_model u_seipc_host_model (.scl_h(scl_h), .sda_h(sda_h), .scl_ln(scl_i), .sda_ln(sda_i));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc_n++;
      if (rx_valid && rx_ready) rx_last <= rx_data;
      if (tx_take) take_n++;
      if (cyc_n == 90000) begin
         bad_count++;
         complete_run();
      end
   end

   task automatic complete_run;
      if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : complete_run

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc

   task automatic cfg(input logic st, input logic au);
      @(negedge clk);
      cfg_stretch_en = st;
      cfg_pd_auto_en = au;
      cfg_wr         = 1'b1;
      @(negedge clk);
      cfg_wr = 1'b0;
   endtask : cfg

   task automatic frame(input logic [7:0] b0, input logic [7:0] b1);
      u_seipc_host_model.start();
      u_seipc_host_model.wbyte(8'h90, ack);
      `seipc_chk(ack, 1'b1)
      u_seipc_host_model.wbyte(b0, ack);
      u_seipc_host_model.wbyte(b1, ack);
      u_seipc_host_model.stop();
      cyc(10);
   endtask : frame

   task automatic enter_pd;
      cfg(1'b0, 1'b1);
      frame(8'h5a, 8'hc5);
      `seipc_chk({pd_active, clk_run, cpu_halt}, 3'h5)
   endtask : enter_pd

   initial begin
      {rst_n, ctl_req, cfg_wr, cfg_stretch_en, cfg_pd_manual_en, cfg_pd_auto_en, pd_req} = 7'h00;
      {deep_sleep_enable_pin, card_rst_n, card_if_en, rx_ready} = 4'hd;
      tx_data = 8'h00;
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      cyc(20);
      `seipc_chk(if_i2c, 1'b1)
      `seipc_chk({scl_oe, sda_oe, high_speed_bus_mode, pd_active, cpu_halt, vout_en}, 6'h01)
      pd_req = 1'b1;
      cyc(1);
      pd_req = 1'b0;
      cyc(5);
      `seipc_chk(pd_active, 1'b0)
      frame(8'h5a, 8'hc5);
      `seipc_chk({proto_known, proto_b, rx_last}, 10'h2c5)
      `seipc_chk(pd_active, 1'b0)
      u_seipc_host_model.start();
      u_seipc_host_model.wbyte(8'h92, ack);
      `seipc_chk(ack, 1'b0)
      u_seipc_host_model.stop();
      enter_pd();
      card_rst_n = 1'b0;
      cyc(10);
      `seipc_chk({pd_active, if_i2c}, 2'h3)
      card_if_en = 1'b1;
      cyc(10);
      card_rst_n = 1'b1;
      cyc(20);
      card_if_en = 1'b0;
      `seipc_chk({pd_active, cpu_halt, if_i2c}, 3'h1)
      enter_pd();
      u_seipc_host_model.start();
      cyc(10);
      `seipc_chk({pd_active, clk_run}, 2'h1)
      u_seipc_host_model.wbyte(8'h90, ack);
      `seipc_chk(ack, 1'b1)
      u_seipc_host_model.stop();
      cyc(1);
      tx_data = 8'ha5;
      u_seipc_host_model.start();
      u_seipc_host_model.wbyte(8'h91, ack);
      `seipc_chk(ack, 1'b1)
      u_seipc_host_model.rbyte(1'b1, rd);
      u_seipc_host_model.stop();
      cyc(1);
      `seipc_chk(rd, 8'ha5)
      `seipc_chk(take_n, 1)
      ctl_req = 1'b1;
      cyc(5);
      `seipc_chk(ctl_active, 1'b1)
      cyc(1000);
      ctl_req = 1'b0;
      cfg(1'b1, 1'b0);
      cyc(2);
      `seipc_chk(high_speed_bus_mode, 1'b1)
      rx_ready = 1'b0;
      fork
         frame(8'h11, 8'h22);
         begin
            wait (scl_oe);
            cyc(200);
            `seipc_chk({scl_i, rx_data}, 9'h011)
            rx_ready = 1'b1;
         end
      join
      `seipc_chk({scl_oe, rx_last}, 9'h022)
      deep_sleep_enable_pin = 1'b0;
      cyc(10);
      `seipc_chk({vout_en, clk_run}, 2'h0)
      deep_sleep_enable_pin = 1'b1;
      cyc(20);
      `seipc_chk({vout_en, if_i2c, high_speed_bus_mode, ctl_active}, 4'hc)
      frame(8'h33, 8'h01);
      `seipc_chk({proto_known, proto_b, rx_last}, 10'h301)
      cfg_pd_manual_en = 1'b1;
      cfg(1'b0, 1'b1);
      pd_req = 1'b1;
      cyc(1);
      pd_req = 1'b0;
      cyc(2);
      `seipc_chk({pd_active, clk_run}, 2'h2)
      frame(8'h33, 8'hcf);
      `seipc_chk({pd_active, clk_run}, 2'h2)
      rx_ready = 1'b0;
      frame(8'h44, 8'h55);
      `seipc_chk({rx_overrun, rx_valid, scl_oe, rx_data}, 11'h655)
      complete_run();
   end
endmodule : seipc_top_tb

`default_nettype wire
